// [design/pacc_top.sv]
// Pulse accumulator, periodic tick and second timer flag register behind APB
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module pacc_top #(
  parameter int TICK_MAX_LOG2 = pacc_pkg::TICK_BASE_LOG2 + 3
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Accumulator input pin
  input wire logic accumulator_input_pin,
  // Interrupt requests: wrap, tick, overflow, edge
  output logic [3:0] irq_req,
  // Timer function select outputs
  output logic compare5_en,
  output logic capture4_en
);
  pacc_pkg::pacc_state_t s_q;
  pacc_pkg::pacc_state_t s_d;
  pacc_pkg::pacc_apb_req_t req;

  // Register select shared by read and write paths
  function automatic logic sel(input logic [7:0] a, input logic [7:0] target);
    sel = (a == target);
  endfunction

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  logic wr_acc;
  logic rd_setup;
  logic e_tick;
  logic pin_now;
  logic rise;
  logic fall;
  logic sel_edge;
  logic active_lvl;
  logic gate_tick;
  logic inc;
  logic tick_done;
  logic [1:0] rate;
  logic [7:0] wdat;
  logic [7:0] set_flags;
  logic [7:0] count_next;
  logic [18:0] tick_limit;

  // Decode and event terms
  always_comb
  begin
    wr_acc = req.psel && req.penable && req.pwrite;
    rd_setup = req.psel && !req.penable && !req.pwrite;
    wdat = req.pwdata[7:0];
    // E clock is pclk over two; the accumulator moves only in the E phase
    e_tick = s_q.e_phase;
    pin_now = s_q.pin_sync[1];
    rise = pin_now && !s_q.pin_prev;
    fall = !pin_now && s_q.pin_prev;
    // Edge select: zero falling, one rising
    sel_edge = s_q.ctrl[pacc_pkg::BIT_EDGESEL] ? rise : fall;
    // Gated inhibit: bit zero blocks while low, one blocks while high
    active_lvl = s_q.ctrl[pacc_pkg::BIT_EDGESEL] ? !pin_now : pin_now;
    gate_tick = e_tick && (s_q.gate_div == 6'(pacc_pkg::GATE_DIV - 1));
    // Event mode samples the pin every E cycle, so edges up to E/2 are seen
    inc = s_q.ctrl[pacc_pkg::BIT_ENABLE] && e_tick &&
          (s_q.ctrl[pacc_pkg::BIT_MODE] ? (gate_tick && active_lvl) : sel_edge);
    rate = s_q.ctrl[pacc_pkg::RATE_LSB +: 2];
    // Period is 2^(13+rate) E cycles, so twice that in pclk cycles
    tick_limit = 19'((19'd1 << (pacc_pkg::TICK_BASE_LOG2 + 32'(rate))) * pacc_pkg::E_DIV - 1);
    tick_done = (s_q.tick_div >= tick_limit);
    count_next = s_q.count + 8'h01;
  end

  // Next state
  always_comb
  begin
    s_d = s_q;
    set_flags = 8'h00;
    if (clk_en)
    begin
      s_d.e_phase = !s_q.e_phase;
      s_d.pin_sync = {s_q.pin_sync[0], accumulator_input_pin};
      if (e_tick)
      begin
        // History moves once per E cycle, so an edge seen in the off phase waits for the next E tick
        s_d.pin_prev = s_q.pin_sync[1];
        s_d.gate_div = s_q.gate_div + 6'h01;
        s_d.main_cnt = s_q.main_cnt + 16'h0001;
        if (s_q.main_cnt == pacc_pkg::MAIN_ONES)
          set_flags[pacc_pkg::BIT_WRAP] = 1'b1;
      end
      // Free-running tick divider restarts at timeout only
      if (tick_done)
      begin
        s_d.tick_div = '0;
        set_flags[pacc_pkg::BIT_TICK] = 1'b1;
      end
      else
        s_d.tick_div = s_q.tick_div + 19'h0_0001;
      if (s_q.ctrl[pacc_pkg::BIT_ENABLE] && e_tick && sel_edge)
        set_flags[pacc_pkg::BIT_EDGE] = 1'b1;
      // Increment in the E phase; reads are captured in the setup cycle
      if (inc)
      begin
        s_d.count = count_next;
        if (s_q.count == pacc_pkg::COUNT_ONES)
          set_flags[pacc_pkg::BIT_OVF] = 1'b1;
      end
      s_d.pready = req.psel && !req.penable;
      // Writes: flags clear on one, set wins over clear
      if (wr_acc)
      begin
        if (sel(req.paddr, pacc_pkg::ADDR_FLAGS))
          s_d.flags = s_q.flags & ~(wdat & pacc_pkg::FLAG_MASK);
        if (sel(req.paddr, pacc_pkg::ADDR_MASK))
          s_d.mask = wdat & pacc_pkg::FLAG_MASK;
        if (sel(req.paddr, pacc_pkg::ADDR_CTRL))
          s_d.ctrl = wdat & pacc_pkg::CTRL_MASK;
        if (sel(req.paddr, pacc_pkg::ADDR_COUNT))
          s_d.count = wdat;
      end
      s_d.flags = s_d.flags | set_flags;
      // Read data captured in setup, driven during access
      if (rd_setup)
      begin
        s_d.prdata = '0;
        case (1'b1)
          sel(req.paddr, pacc_pkg::ADDR_FLAGS): s_d.prdata[7:0] = s_q.flags & pacc_pkg::FLAG_MASK;
          sel(req.paddr, pacc_pkg::ADDR_MASK): s_d.prdata[7:0] = s_q.mask;
          sel(req.paddr, pacc_pkg::ADDR_CTRL): s_d.prdata[7:0] = s_q.ctrl;
          sel(req.paddr, pacc_pkg::ADDR_COUNT): s_d.prdata[7:0] = s_q.count;
          sel(req.paddr, pacc_pkg::ADDR_MAIN_LO): s_d.prdata[7:0] = s_q.main_cnt[7:0];
          sel(req.paddr, pacc_pkg::ADDR_MAIN_HI): s_d.prdata[7:0] = s_q.main_cnt[15:8];
          default: s_d.prdata = '0;
        endcase
      end
      // Requests follow flags; enables never touch flags
      s_d.irq = s_q.flags[7:4] & s_q.mask[7:4];
      s_d.compare5_en = !s_q.ctrl[pacc_pkg::BIT_CAPSEL];
      s_d.capture4_en = s_q.ctrl[pacc_pkg::BIT_CAPSEL];
    end
  end

  // State register; count has no reset value in the real part, zero here for X safety
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.compare5_en <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops, pslverr tied low
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = 1'b0;
  assign irq_req = s_q.irq;
  assign compare5_en = s_q.compare5_en;
  assign capture4_en = s_q.capture4_en;

  // Checks
  // The wrap from all ones raises the wrap flag
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && e_tick && s_q.main_cnt == pacc_pkg::MAIN_ONES) |=> s_q.flags[pacc_pkg::BIT_WRAP];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");

  // A one on the edge bit clears it unless an edge lands too
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_acc && sel(req.paddr, pacc_pkg::ADDR_FLAGS) && wdat[pacc_pkg::BIT_EDGE] && !set_flags[pacc_pkg::BIT_EDGE])
      |=> !s_q.flags[pacc_pkg::BIT_EDGE];
  endproperty
  a_clear: assert property (p_clear) else $error("edge flag not cleared");

  // Timeout sets the tick flag and restarts the divider
  property p_tick;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && tick_done) |=> (s_q.flags[pacc_pkg::BIT_TICK] && s_q.tick_div == '0);
  endproperty
  a_tick: assert property (p_tick) else $error("tick flag missing");

  // Unused low flag bits never hold a one
  property p_low;
    @(posedge pclk) disable iff (!presetn)
      pready |-> (s_q.flags[3:0] == 4'h0);
  endproperty
  a_low: assert property (p_low) else $error("low flag bits set");

  // A disabled accumulator keeps its count
  property p_off;
    @(posedge pclk) disable iff (!presetn)
      (!s_q.ctrl[pacc_pkg::BIT_ENABLE] && !wr_acc) |=> $stable(s_q.count);
  endproperty
  a_off: assert property (p_off) else $error("count moved while off");

  // Rolling over from all ones wraps to zero and flags it; a count write wins
  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && inc && s_q.count == pacc_pkg::COUNT_ONES && !(wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT)))
      |=> (s_q.count == 8'h00 && s_q.flags[pacc_pkg::BIT_OVF]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");

  // Each request line is flag and mask, one cycle late
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      clk_en ##1 clk_en |-> irq_req == ($past(s_q.flags[7:4]) & $past(s_q.mask[7:4]));
  endproperty
  a_irq: assert property (p_irq) else $error("request mismatch");

  // Exactly one of compare5 and capture4 is live
  property p_sel;
    @(posedge pclk) disable iff (!presetn)
      compare5_en != capture4_en;
  endproperty
  a_sel: assert property (p_sel) else $error("both functions active");

  // A selected edge with the accumulator enabled always leaves the edge flag set
  property p_edge_set;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.ctrl[pacc_pkg::BIT_ENABLE] && e_tick && sel_edge)
      |=> s_q.flags[pacc_pkg::BIT_EDGE];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  // Enabled edge flag raises its own request
  property p_edge_irq;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.flags[pacc_pkg::BIT_EDGE] && s_q.mask[pacc_pkg::BIT_EDGE])
      |=> irq_req[0];
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge request missing");

  // Enabled overflow flag raises its own request
  property p_ovf_irq;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.flags[pacc_pkg::BIT_OVF] && s_q.mask[pacc_pkg::BIT_OVF])
      |=> irq_req[1];
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

  // Enabled wrap flag pairs with the mask bit in the same place
  property p_wrap_irq;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.flags[pacc_pkg::BIT_WRAP] && s_q.mask[pacc_pkg::BIT_WRAP])
      |=> irq_req[3];
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap request missing");

  // A masked tick never requests
  property p_tick_mask;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && !s_q.mask[pacc_pkg::BIT_TICK])
      |=> !irq_req[2];
  endproperty
  a_tick_mask: assert property (p_tick_mask) else $error("masked tick requested");

  // Bit six written high clears the tick flag when no timeout lands
  property p_tick_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_acc && sel(req.paddr, pacc_pkg::ADDR_FLAGS) && wdat[pacc_pkg::BIT_TICK] && !tick_done)
      |=> !s_q.flags[pacc_pkg::BIT_TICK];
  endproperty
  a_tick_clear: assert property (p_tick_clear) else $error("tick flag not cleared");

  // Bit five written high clears the overflow flag when no rollover lands
  property p_ovf_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_acc && sel(req.paddr, pacc_pkg::ADDR_FLAGS) && wdat[pacc_pkg::BIT_OVF] && !set_flags[pacc_pkg::BIT_OVF])
      |=> !s_q.flags[pacc_pkg::BIT_OVF];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  // A zero written to a flag never loses it
  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_acc && sel(req.paddr, pacc_pkg::ADDR_FLAGS))
      |=> (($past(s_q.flags) & ~$past(wdat) & ~s_q.flags) == 8'h00);
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost on zero write");

  // Inactive gate level holds the count
  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.ctrl[pacc_pkg::BIT_ENABLE] && s_q.ctrl[pacc_pkg::BIT_MODE] && !active_lvl && !(wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT)))
      |=> $stable(s_q.count);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved while gated off");

  // Event mode without a selected edge holds the count
  property p_event_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.ctrl[pacc_pkg::BIT_ENABLE] && !s_q.ctrl[pacc_pkg::BIT_MODE] && !(e_tick && sel_edge) && !(wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT)))
      |=> $stable(s_q.count);
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("count moved without edge");

  // A selected edge in event mode adds exactly one
  property p_event_inc;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.ctrl[pacc_pkg::BIT_ENABLE] && !s_q.ctrl[pacc_pkg::BIT_MODE] && e_tick && sel_edge && !(wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT)))
      |=> s_q.count == 8'($past(s_q.count) + 8'h01);
  endproperty
  a_event_inc: assert property (p_event_inc) else $error("edge not counted");

  // A gate tick at the active level adds exactly one
  property p_gate_inc;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && s_q.ctrl[pacc_pkg::BIT_ENABLE] && s_q.ctrl[pacc_pkg::BIT_MODE] && gate_tick && active_lvl && !(wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT)))
      |=> s_q.count == 8'($past(s_q.count) + 8'h01);
  endproperty
  a_gate_inc: assert property (p_gate_inc) else $error("gate tick not counted");

  // A count write always lands, counting or not
  property p_count_wr;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_acc && sel(req.paddr, pacc_pkg::ADDR_COUNT))
      |=> s_q.count == $past(wdat);
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write lost");

  // Count read returns the value from the setup cycle
  property p_rd_count;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rd_setup && sel(req.paddr, pacc_pkg::ADDR_COUNT))
      |=> prdata == {24'h00_0000, $past(s_q.count)};
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count read wrong");

  // Flag reads show zero in the low nibble
  property p_rd_flags;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && rd_setup && sel(req.paddr, pacc_pkg::ADDR_FLAGS))
      |=> prdata[3:0] == 4'h0;
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("low flag bits read high");

  // Capture select follows its control bit
  property p_capsel;
    @(posedge pclk) disable iff (!presetn)
      clk_en
      |=> capture4_en == $past(s_q.ctrl[pacc_pkg::BIT_CAPSEL]);
  endproperty
  a_capsel: assert property (p_capsel) else $error("capture select wrong");
endmodule // pacc_top

// [design/pacc_pkg.sv]
// Package for the pulse accumulator and periodic tick block
package pacc_pkg;
  // Byte addresses of the registers on APB
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_MAIN_LO = 8'h10;
  localparam logic [7:0] ADDR_MAIN_HI = 8'h14;
  // Flag and mask bit positions (shared layout)
  localparam int BIT_WRAP = 7;
  localparam int BIT_TICK = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_EDGE = 4;
  // Control bit positions
  localparam int BIT_ENABLE = 6;
  localparam int BIT_MODE = 5;
  localparam int BIT_EDGESEL = 4;
  localparam int BIT_CAPSEL = 2;
  localparam int RATE_LSB = 0;
  // Implemented bit masks
  localparam logic [7:0] FLAG_MASK = 8'hF0;
  localparam logic [7:0] CTRL_MASK = 8'h77;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Periodic tick base exponent, gate tick divide, E clock divide
  localparam int TICK_BASE_LOG2 = 13;
  localparam int GATE_DIV = 64;
  localparam int E_DIV = 2;
  localparam logic [15:0] MAIN_ONES = 16'hFFFF;
  localparam logic [7:0] COUNT_ONES = 8'hFF;
  // APB request carried as one struct
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pacc_apb_req_t;
  // Whole block state
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [15:0] main_cnt;
    logic [18:0] tick_div;
    logic [5:0] gate_div;
    logic e_phase;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [31:0] prdata;
    logic pready;
    logic [3:0] irq;
    logic compare5_en;
    logic capture4_en;
  } pacc_state_t;
endpackage

// [testbench/pacc_pin_model.sv]
// Drive model for the accumulator input pin
`timescale 1ns/1ps
module pacc_pin_model (
  // Clock
  input wire logic pclk,
  // Pin
  output logic accumulator_input_pin
);
  initial accumulator_input_pin = 1'b1;
  // Four clocks per level keeps events well under the E/2 limit
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge pclk) accumulator_input_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      accumulator_input_pin <= 1'b1;
      repeat (4) @(posedge pclk);
    end
  endtask
  // Static gating level
  task automatic level(input logic v);
    @(posedge pclk) accumulator_input_pin <= v;
  endtask
endmodule // pacc_pin_model

// [testbench/tb_top.sv]
// Self-checking bench for the pulse accumulator block
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pin;
  logic [3:0] irq_req;
  logic compare5_en;
  logic capture4_en;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  int t1;
  logic [7:0] r;
  // Clock and a cycle count used for interval timing
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  pacc_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .accumulator_input_pin(pin), .irq_req(irq_req), .compare5_en(compare5_en), .capture4_en(capture4_en));
  pacc_pin_model pm (.pclk(pclk), .accumulator_input_pin(pin));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      mismatches++;
      close_out();
    end
  endtask
  // Waits for the tick request, time-stamping it
  task automatic wait_tick(output int t);
    int i;
    for (i = 0; i < 40000 && irq_req[2] !== 1'b1; i++)
      @(posedge pclk);
    t = cyc;
    if (i >= 40000)
    begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic t_reset();
    apb(0, pacc_pkg::ADDR_CTRL, 8'h00);
    cmp(r, 8'h00);
    apb(0, pacc_pkg::ADDR_MASK, 8'h00);
    cmp(r, 8'h00);
    apb(0, 8'h18, 8'h00);
    cmp(r, 8'h00);
    apb(1, pacc_pkg::ADDR_FLAGS, 8'h0F);
    apb(0, pacc_pkg::ADDR_FLAGS, 8'h00);
    cmp(r, 8'h00);
    cmp({compare5_en, capture4_en}, 2'b10);
    cmp(irq_req[3], 1'b0);
    apb(1, pacc_pkg::ADDR_CTRL, 8'h04);
    repeat (2) @(posedge pclk);
    cmp({compare5_en, capture4_en}, 2'b01);
    $display("test reset done");
  endtask
  // Both edge selections, flag clearing, overflow and requests
  task automatic t_events();
    for (int e = 0; e < 2; e++)
    begin
      apb(1, pacc_pkg::ADDR_CTRL, 8'h40 | (e << 4));
      apb(1, pacc_pkg::ADDR_COUNT, 8'h00);
      apb(1, pacc_pkg::ADDR_FLAGS, 8'h10);
      pm.pulse(3);
      apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
      cmp(r, 8'h03);
      apb(1, pacc_pkg::ADDR_FLAGS, 8'h00);
      apb(0, pacc_pkg::ADDR_FLAGS, 8'h00);
      cmp(r & 8'h30, 8'h10);
      apb(1, pacc_pkg::ADDR_FLAGS, 8'h10);
      apb(0, pacc_pkg::ADDR_FLAGS, 8'h00);
      cmp(r & 8'h30, 8'h00);
    end
    apb(1, pacc_pkg::ADDR_CTRL, 8'h10);
    pm.pulse(2);
    apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
    cmp(r, 8'h03);
    apb(1, pacc_pkg::ADDR_CTRL, 8'h50);
    apb(1, pacc_pkg::ADDR_COUNT, 8'hFE);
    apb(1, pacc_pkg::ADDR_MASK, 8'h30);
    pm.pulse(2);
    apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
    cmp(r, 8'h00);
    apb(0, pacc_pkg::ADDR_FLAGS, 8'h00);
    cmp(r & 8'h30, 8'h30);
    cmp(irq_req[1:0], 2'b11);
    apb(1, pacc_pkg::ADDR_FLAGS, 8'h30);
    repeat (2) @(posedge pclk);
    cmp(irq_req[1:0], 2'b00);
    $display("test events done");
  endtask
  // Low level inhibits, high level counts E/64 ticks
  task automatic t_gated();
    apb(1, pacc_pkg::ADDR_CTRL, 8'h60);
    pm.level(1'b0);
    apb(1, pacc_pkg::ADDR_COUNT, 8'h00);
    repeat (400) @(posedge pclk);
    apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
    cmp(r, 8'h00);
    pm.level(1'b1);
    repeat (512) @(posedge pclk);
    apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
    cmp(r >= 8'h03 && r <= 8'h05, 1'b1);
    apb(1, pacc_pkg::ADDR_CTRL, 8'h70);
    apb(1, pacc_pkg::ADDR_COUNT, 8'h00);
    repeat (300) @(posedge pclk);
    apb(0, pacc_pkg::ADDR_COUNT, 8'h00);
    cmp(r, 8'h00);
    $display("test gated done");
  endtask
  // Tick timing at rates zero and one, periods 2 * 2^13 and 2 * 2^14 clocks
  task automatic t_tick(input int rel);
    apb(1, pacc_pkg::ADDR_CTRL, 8'h00);
    apb(1, pacc_pkg::ADDR_MASK, 8'h40);
    wait_tick(t0);
    cmp(t0 - rel >= 16384 && t0 - rel <= 16390, 1'b1);
    apb(1, pacc_pkg::ADDR_FLAGS, 8'h40);
    repeat (2) @(posedge pclk);
    wait_tick(t1);
    cmp(t1 - t0, 16384);
    apb(1, pacc_pkg::ADDR_CTRL, 8'h01);
    apb(1, pacc_pkg::ADDR_FLAGS, 8'h40);
    repeat (2) @(posedge pclk);
    wait_tick(t0);
    cmp(t0 - t1, 32768);
    apb(1, pacc_pkg::ADDR_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    cmp(irq_req[2], 1'b0);
    apb(0, pacc_pkg::ADDR_FLAGS, 8'h00);
    cmp(r & 8'h40, 8'h40);
    $display("test tick done");
  endtask
  // Clock enable low freezes the main counter; only the four live edges advance it
  task automatic t_freeze();
    logic [7:0] r0;
    apb(0, pacc_pkg::ADDR_MAIN_LO, 8'h00);
    r0 = r;
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (300) @(posedge pclk);
    clk_en <= 1'b1;
    apb(0, pacc_pkg::ADDR_MAIN_LO, 8'h00);
    cmp(8'(r - r0), 8'h02);
    $display("test freeze done");
  endtask
  // Reset held four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    t_reset();
    t_events();
    t_gated();
    t_tick(t0);
    t_freeze();
    close_out();
  end
endmodule // tb_top
